// file: rtl/rxscc_pkg.sv
/*
 * rxscc_pkg: register map, field positions, reset values and encodings for
 * the receiver sync / demodulator / correlator configuration bank.
 * Assumes a single AHB-Lite slave on a 32-bit bus, one register per word.
 */
// Functional notes
// - sync bits 7..4 give valid pattern bits
// - sync bit 3 grids on first falling correlation
// - sync bit 2 halves final pattern bit
// - style 0 treats sixteen bits as burst
// - style 1 nibble is data/collision pair
// - style 2 resyncs per byte; 3 reserved
// - demod bit 5 averages four samples
// - demod bit 4 squares samples rectangular
// - demod bit 3 grid at peak or minimum
// - demod bit 2 picks Manchester polarity
// - demod bit 1 selects FREQUENCY_SHIFT_DEMOD demodulation
// - demod bit 0 selects PHASE_SHIFT_DEMOD demodulation
// - correlator bits 5..4 set correlation rate
// - correlator bit 3 shortens window to 32
// - read-only revision register at index 7F
// - pattern held as high and low bytes
package rxscc_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [6:0] RXSCC_IDX_PAT_HIGH = 7'h5A;
   localparam logic [6:0] RXSCC_IDX_PAT_LOW  = 7'h5B;
   localparam logic [6:0] RXSCC_IDX_SYNC     = 7'h5C;
   localparam logic [6:0] RXSCC_IDX_DEMOD    = 7'h5D;
   localparam logic [6:0] RXSCC_IDX_CORR     = 7'h5E;
   localparam logic [6:0] RXSCC_IDX_TRIM     = 7'h5F;
   localparam logic [6:0] RXSCC_IDX_REV      = 7'h7F;

   // ----------------------------------------------------------------
   // field positions and writable masks
   // ----------------------------------------------------------------
   localparam int RXSCC_SYNC_LEN_LSB   = 4;
   localparam int RXSCC_SYNC_NEG_BIT   = 3;
   localparam int RXSCC_SYNC_HALF_BIT  = 2;
   localparam int RXSCC_SYNC_STYLE_LSB = 0;
   localparam int RXSCC_DEM_AVG_BIT    = 5;
   localparam int RXSCC_DEM_SQR_BIT    = 4;
   localparam int RXSCC_DEM_PEAK_BIT   = 3;
   localparam int RXSCC_DEM_POL_BIT    = 2;
   localparam int RXSCC_DEM_FSK_BIT    = 1;
   localparam int RXSCC_DEM_PHASE_SHIFT_DEMOD_BIT   = 0;
   localparam int RXSCC_COR_FREQ_LSB   = 6;
   localparam int RXSCC_COR_RATE_LSB   = 4;
   localparam int RXSCC_COR_SHORT_BIT  = 3;
   localparam logic [7:0] RXSCC_DEMOD_WMASK = 8'h3F;
   localparam logic [7:0] RXSCC_CORR_WMASK  = 8'hF8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RXSCC_RST_PAT_HIGH = 8'h00;
   localparam logic [7:0] RXSCC_RST_PAT_LOW  = 8'h00;
   localparam logic [7:0] RXSCC_RST_SYNC     = 8'h00;
   localparam logic [7:0] RXSCC_RST_DEMOD    = 8'h00;
   localparam logic [7:0] RXSCC_RST_CORR     = 8'h00;
   localparam logic [7:0] RXSCC_RST_TRIM     = 8'h00;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RXSCC_STYLE_BURST    = 2'h0,
      RXSCC_STYLE_DATACOLL = 2'h1,
      RXSCC_STYLE_PERBYTE  = 2'h2,
      RXSCC_STYLE_RSVD     = 2'h3
   } rxscc_style_t;

   typedef enum logic [1:0] {
      RXSCC_RATE_PROX   = 2'h0,
      RXSCC_RATE_FAST   = 2'h1,
      RXSCC_RATE_SLOW   = 2'h2,
      RXSCC_RATE_RSVD   = 2'h3
   } rxscc_rate_t;

   localparam logic [6:0] RXSCC_WIN_LONG  = 7'd64;
   localparam logic [6:0] RXSCC_WIN_SHORT = 7'd32;

endpackage

// file: rtl/rxscc_sof_decode.sv
/*
 * rxscc_sof_decode: turns the stored start-of-frame pattern and sync
 * control into the expected-bit masks used by the frame detector.
 * Assumes the inputs are register outputs in the same clock domain.
 */
`timescale 1ns/1ps
module rxscc_sof_decode
   import rxscc_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // pattern and control
   input  wire logic [15:0] pattern,
   input  wire logic [3:0]  valid_count,
   input  wire logic [1:0]  style,
   // decoded expectation
   output logic [15:0]      expect_bits,
   output logic [15:0]      expect_valid,
   output logic [3:0]       expect_coll,
   output logic             per_byte_sync,
   output logic             style_illegal
);

   logic [15:0] bits_nxt;
   logic [15:0] valid_nxt;
   logic [3:0]  coll_nxt;
   logic [15:0] bits_r;
   logic [15:0] valid_r;
   logic [3:0]  coll_r;
   logic        byte_r;
   logic        ill_r;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // valid bits counted from the top of the pattern, first sent first
   always_comb begin
      bits_nxt  = 16'h0000;
      valid_nxt = 16'h0000;
      coll_nxt  = 4'h0;
      for (int i = 0; i < 16; i++) begin
         valid_nxt[15 - i] = (5'(i) < {1'b0, valid_count});
      end
      unique case (style)
         RXSCC_STYLE_BURST: begin
            bits_nxt = pattern;
         end
         RXSCC_STYLE_DATACOLL: begin
            // nibble = {data, coll}; a set collision flag masks data
            for (int n = 0; n < 4; n++) begin
               coll_nxt[n]       = pattern[4*n];
               bits_nxt[4*n + 3] = pattern[4*n + 3] & ~pattern[4*n];
            end
         end
         default: begin
            bits_nxt = 16'h0000; // per-byte or reserved: no pattern
         end
      endcase
   end

   // registered so the detector sees a stable copy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bits_r  <= 16'h0000;
         valid_r <= 16'h0000;
         coll_r  <= 4'h0;
         byte_r  <= 1'b0;
         ill_r   <= 1'b0;
      end else begin
         bits_r  <= bits_nxt;
         valid_r <= valid_nxt;
         coll_r  <= coll_nxt;
         byte_r  <= (style == RXSCC_STYLE_PERBYTE);
         ill_r   <= (style == RXSCC_STYLE_RSVD);
      end
   end

   assign expect_bits   = bits_r;
   assign expect_valid  = valid_r;
   assign expect_coll   = coll_r;
   assign per_byte_sync = byte_r;
   assign style_illegal = ill_r;

endmodule

// file: rtl/rxscc_top.sv
/*
 * rxscc_top: AHB-Lite register bank configuring receiver start-of-frame
 * sync, demodulator and correlator; drives decoded controls to the
 * receive datapath.
 * Assumes one AHB-Lite master, single word transfers, hclk at 50 MHz.
 */
`timescale 1ns/1ps
module rxscc_top
   import rxscc_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'hA5 // arbitrary value
)(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // start-of-frame controls
   output logic [15:0]      sof_expect_bits,
   output logic [15:0]      sof_expect_valid,
   output logic [3:0]       sof_expect_coll,
   output logic             sof_per_byte_sync,
   output logic             sof_style_illegal,
   output logic             grid_on_falling_correlation,
   output logic             final_sof_bit_half,
   // demodulator controls
   output logic             sample_averager_on,
   output logic [1:0]       average_group_log2,
   output logic             squaring_shaper_on,
   output logic             grid_at_correlation_peak,
   output logic             manchester_polarity,
   output logic             frequency_shift_demod,
   output logic             phase_shift_demod,
   // correlator controls
   output logic [1:0]       correlator_freq,
   output logic [1:0]       correlator_rate,
   output logic             correlator_rate_illegal,
   output logic             short_correlation_window,
   output logic [6:0]       correlation_length,
   output logic [7:0]       factory_receiver_trim
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] pat_high_r, pat_high_nxt;
   logic [7:0] pat_low_r,  pat_low_nxt;
   logic [7:0] sync_r,     sync_nxt;
   logic [7:0] demod_r,    demod_nxt;
   logic [7:0] corr_r,     corr_nxt;
   logic [7:0] trim_r,     trim_nxt;
   logic       wr_pend_r,  wr_pend_nxt;
   logic [6:0] idx_r,      idx_nxt;
   logic [31:0] rdata_r,   rdata_nxt;

   logic       addr_phase;
   logic       aligned;
   logic [6:0] req_idx;

   // index of a register: byte address over four
   function automatic logic [6:0] word_index(input logic [31:0] a);
      return a[8:2];
   endfunction

   // read mux, shared by the read path; unmapped reads return zero
   function automatic logic [7:0] read_reg(input logic [6:0] i,
                                           input logic [7:0] ph,
                                           input logic [7:0] pl,
                                           input logic [7:0] sy,
                                           input logic [7:0] dm,
                                           input logic [7:0] co,
                                           input logic [7:0] tr);
      logic [7:0] v;
      v = 8'h00;
      unique case (i)
         RXSCC_IDX_PAT_HIGH: v = ph;
         RXSCC_IDX_PAT_LOW:  v = pl;
         RXSCC_IDX_SYNC:     v = sy;
         RXSCC_IDX_DEMOD:    v = dm & RXSCC_DEMOD_WMASK;
         RXSCC_IDX_CORR:     v = co & RXSCC_CORR_WMASK;
         RXSCC_IDX_TRIM:     v = tr;
         RXSCC_IDX_REV:      v = REVISION;
         default:            v = 8'h00;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   // zero wait states: data phase always completes in one cycle, OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel & hready & htrans[1];
   assign aligned    = (haddr[1:0] == 2'b00);
   assign req_idx    = word_index(haddr);

   // address phase capture and read data, read in the next cycle
   always_comb begin
      wr_pend_nxt = addr_phase & hwrite & aligned;
      idx_nxt     = addr_phase ? req_idx : idx_r;
      rdata_nxt   = rdata_r;
      if (addr_phase && !hwrite) begin
         // read sees any write completing in this same cycle
         rdata_nxt = {24'h000000,
                      read_reg(req_idx, pat_high_nxt, pat_low_nxt,
                               sync_nxt, demod_nxt, corr_nxt, trim_nxt)};
         if (!aligned) begin
            rdata_nxt = 32'h00000000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         idx_r     <= 7'h00;
         rdata_r   <= 32'h00000000;
      end else begin
         wr_pend_r <= wr_pend_nxt;
         idx_r     <= idx_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign hrdata = rdata_r;

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // write data arrives in the data phase; low byte lane only
   always_comb begin
      pat_high_nxt = pat_high_r;
      pat_low_nxt  = pat_low_r;
      sync_nxt     = sync_r;
      demod_nxt    = demod_r;
      corr_nxt     = corr_r;
      trim_nxt     = trim_r;
      if (wr_pend_r) begin
         unique case (idx_r)
            RXSCC_IDX_PAT_HIGH: pat_high_nxt = hwdata[7:0];
            RXSCC_IDX_PAT_LOW:  pat_low_nxt  = hwdata[7:0];
            RXSCC_IDX_SYNC:     sync_nxt     = hwdata[7:0];
            RXSCC_IDX_DEMOD:
               demod_nxt = hwdata[7:0] & RXSCC_DEMOD_WMASK;
            RXSCC_IDX_CORR:
               corr_nxt  = hwdata[7:0] & RXSCC_CORR_WMASK;
            // trim stays writable; keeping the boot value is software's job
            RXSCC_IDX_TRIM:     trim_nxt     = hwdata[7:0];
            default:            ; // revision and unmapped: ignored
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pat_high_r <= RXSCC_RST_PAT_HIGH;
         pat_low_r  <= RXSCC_RST_PAT_LOW;
         sync_r     <= RXSCC_RST_SYNC;
         demod_r    <= RXSCC_RST_DEMOD;
         corr_r     <= RXSCC_RST_CORR;
         trim_r     <= RXSCC_RST_TRIM;
      end else begin
         pat_high_r <= pat_high_nxt;
         pat_low_r  <= pat_low_nxt;
         sync_r     <= sync_nxt;
         demod_r    <= demod_nxt;
         corr_r     <= corr_nxt;
         trim_r     <= trim_nxt;
      end
   end

   // ----------------------------------------------------------------
   // start-of-frame pattern decode
   // ----------------------------------------------------------------
   rxscc_sof_decode u_sof (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .pattern       ({pat_high_r, pat_low_r}),
      .valid_count   (sync_r[RXSCC_SYNC_LEN_LSB +: 4]),
      .style         (sync_r[RXSCC_SYNC_STYLE_LSB +: 2]),
      .expect_bits   (sof_expect_bits),
      .expect_valid  (sof_expect_valid),
      .expect_coll   (sof_expect_coll),
      .per_byte_sync (sof_per_byte_sync),
      .style_illegal (sof_style_illegal)
   );

   // ----------------------------------------------------------------
   // control outputs, straight from register bits
   // ----------------------------------------------------------------
   // sync grid controls
   assign grid_on_falling_correlation = sync_r[RXSCC_SYNC_NEG_BIT];
   assign final_sof_bit_half          = sync_r[RXSCC_SYNC_HALF_BIT];

   // demodulator; averaging groups four samples, i.e. shift by two
   assign sample_averager_on = demod_r[RXSCC_DEM_AVG_BIT];
   assign average_group_log2 = demod_r[RXSCC_DEM_AVG_BIT] ? 2'd2 : 2'd0;
   assign squaring_shaper_on = demod_r[RXSCC_DEM_SQR_BIT];
   assign grid_at_correlation_peak = demod_r[RXSCC_DEM_PEAK_BIT];
   assign manchester_polarity   = demod_r[RXSCC_DEM_POL_BIT];
   assign frequency_shift_demod = demod_r[RXSCC_DEM_FSK_BIT];
   assign phase_shift_demod     = demod_r[RXSCC_DEM_PHASE_SHIFT_DEMOD_BIT];

   // correlator; reserved rate flagged so the datapath can hold off
   assign correlator_freq  = corr_r[RXSCC_COR_FREQ_LSB +: 2];
   assign correlator_rate  = corr_r[RXSCC_COR_RATE_LSB +: 2];
   assign correlator_rate_illegal =
      (corr_r[RXSCC_COR_RATE_LSB +: 2] == RXSCC_RATE_RSVD);
   assign short_correlation_window = corr_r[RXSCC_COR_SHORT_BIT];
   assign correlation_length = corr_r[RXSCC_COR_SHORT_BIT] ?
                               RXSCC_WIN_SHORT : RXSCC_WIN_LONG;

   assign factory_receiver_trim = trim_r;

endmodule

// file: tb/rxscc_asserts.sv
/*
 * rxscc_asserts: bus-side checks of the configuration bank.
 * Assumes hready is looped back from hreadyout, word transfers only.
 */
`timescale 1ns/1ps
module rxscc_asserts
   import rxscc_pkg::*;
#(
   parameter logic [7:0] REVISION = 8'hA5 // arbitrary value
)(
   // clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // decoded controls
   input wire logic [15:0] sof_expect_valid,
   input wire logic        sof_per_byte_sync,
   input wire logic        sof_style_illegal,
   input wire logic        grid_on_falling_correlation,
   input wire logic        final_sof_bit_half,
   input wire logic        sample_averager_on,
   input wire logic [1:0]  average_group_log2,
   input wire logic        squaring_shaper_on,
   input wire logic        grid_at_correlation_peak,
   input wire logic        manchester_polarity,
   input wire logic        frequency_shift_demod,
   input wire logic        phase_shift_demod,
   input wire logic [1:0]  correlator_rate,
   input wire logic        correlator_rate_illegal,
   input wire logic        short_correlation_window,
   input wire logic [6:0]  correlation_length
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------------------------------
   // write address phase then its data phase
   // ----------------------------------------------------------------
   sequence s_wr(logic [31:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == a ##1 1'b1;
   endsequence
   sequence s_rd(logic [31:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence
   // sof decode is registered once more, hence two cycles
   chk_sof_count: assert property (s_wr(32'h170) |-> ##2
      sof_expect_valid == 16'(~(16'hFFFF >> $past(hwdata[7:4], 2))))
      else $error("valid mask does not follow count");
   chk_style_flags: assert property (s_wr(32'h170) |-> ##2
      sof_per_byte_sync == ($past(hwdata[1:0], 2) == 2'h2) &&
      sof_style_illegal == ($past(hwdata[1:0], 2) == 2'h3))
      else $error("style flags wrong");
   chk_sync_bits: assert property (s_wr(32'h170) |=>
      grid_on_falling_correlation == $past(hwdata[3]) &&
      final_sof_bit_half == $past(hwdata[2]))
      else $error("sync control bits wrong");
   chk_demod_bits: assert property (s_wr(32'h174) |=>
      {sample_averager_on, squaring_shaper_on, grid_at_correlation_peak,
       manchester_polarity, frequency_shift_demod, phase_shift_demod}
      == $past(hwdata[5:0]))
      else $error("demodulator bits wrong");
   chk_avg_group: assert property (
      average_group_log2 == (sample_averager_on ? 2'h2 : 2'h0))
      else $error("average group wrong");
   chk_corr_rate: assert property (s_wr(32'h178) |=>
      correlator_rate == $past(hwdata[5:4]) &&
      correlator_rate_illegal == ($past(hwdata[5:4]) == 2'h3))
      else $error("correlator rate wrong");
   chk_corr_len: assert property (
      correlation_length == (short_correlation_window ? 7'd32 : 7'd64))
      else $error("correlation length wrong");
   chk_rev_read: assert property (s_rd(32'h1FC) |=>
      hrdata == {24'h0, REVISION})
      else $error("revision read wrong");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
endmodule
bind rxscc_top rxscc_asserts #(.REVISION(REVISION)) i_rxscc_asserts (.*);

// file: tb/rxscc_host.sv
/*
 * rxscc_host: ahb-lite master standing in for host software.
 * Assumes one slave whose hreadyout is looped back as hready.
 */
`timescale 1ns/1ps
module rxscc_host (
   // clock
   input  wire logic        hclk,
   // ahb-lite master side
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   logic tmo;
   // idle bus from time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
      tmo    = 1'b0;
   end
   // bounded so a stuck slave cannot hang the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) tmo = 1'b1;
   endtask
   // one single word transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wr ? d : ~hwdata; // reads toggle data so no stale match
      wait_ready();
      q = hrdata;
   endtask
endmodule

// file: tb/rxscc_top_tb.sv
/*
 * rxscc_top_tb: self-checking bench for the configuration bank.
 * Assumes the host model drives the bus and hready is looped back.
 */
`timescale 1ns/1ps
module rxscc_top_tb;
   import rxscc_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0]  htrans, average_group_log2, correlator_freq;
   logic [1:0]  correlator_rate;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [15:0] sof_expect_bits, sof_expect_valid;
   logic [3:0]  sof_expect_coll;
   logic        sof_per_byte_sync, sof_style_illegal;
   logic        grid_on_falling_correlation, final_sof_bit_half;
   logic        sample_averager_on, squaring_shaper_on;
   logic        grid_at_correlation_peak, manchester_polarity;
   logic        frequency_shift_demod, phase_shift_demod;
   logic        correlator_rate_illegal, short_correlation_window;
   logic [6:0]  correlation_length;
   logic [7:0]  factory_receiver_trim;
   logic [5:0]  demod_seen;
   int          n_mismatch, tests_run;
   typedef struct {
      logic [31:0] a;
      logic [31:0] d;
      logic [31:0] q;
   } rxscc_row_t;
   // address, write data, expected read back
   rxscc_row_t rows [7] = '{
      '{32'h168, 32'hFFFF_FF91, 32'h91},
      '{32'h16C, 32'h0000_0080, 32'h80},
      '{32'h174, 32'h0000_00FF, 32'h3F},
      '{32'h178, 32'h0000_00FF, 32'hF8},
      '{32'h1FC, 32'h0000_0012, {24'h0, REV}},
      '{32'h100, 32'h0000_0077, 32'h0},
      '{32'h17E, 32'h0000_0044, 32'h0}
   };
   assign hready = hreadyout;
   assign demod_seen = {sample_averager_on, squaring_shaper_on,
      grid_at_correlation_peak, manchester_polarity,
      frequency_shift_demod, phase_shift_demod};
   rxscc_top #(.REVISION(REV)) i_rxscc_top (.*);
   rxscc_host i_rxscc_host (.*);
   // ----------------------------------------------------------------
   // clock, report and helpers
   // ----------------------------------------------------------------
   initial hclk = 1'b0;
   always #10 hclk = ~hclk;
   task automatic finish_test();
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] unused;
      i_rxscc_host.xfer(1'b1, a, d, unused);
   endtask
   // a bus wait that ran out ends the run as a failure
   always @(posedge hclk) begin
      if (i_rxscc_host.tmo === 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // write then read back at once, with one idle address phase between
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         i_rxscc_host.xfer(1'b0, rows[k].a, 32'h0, q);
         check(q, rows[k].q);
      end
      // every sync style and edge-bit pair, counts 0, 5, 10 and 15; pattern is 9180
      for (int s = 0; s < 4; s++) begin
         wr(32'h170, {24'h0, 4'(s * 5), 2'(s), 2'(s)});
         repeat (3) @(posedge hclk);
         check(sof_expect_valid, 16'(~(16'hFFFF >> (s * 5))));
         if (s == 0) check(sof_expect_bits, 32'h9180);
         if (s == 1) check(sof_expect_bits, 32'h0080);
         if (s == 1) check(sof_expect_coll, 32'hC);
         if (s >= 2) check(sof_expect_bits, 32'h0);
         check({sof_per_byte_sync, sof_style_illegal}, {s == 2, s == 3});
         check(grid_on_falling_correlation, 32'(s >> 1));
         check(final_sof_bit_half, 32'(s & 1));
      end
      // walking one through the demodulator bits
      for (int i = 0; i < 6; i++) begin
         wr(32'h174, 32'h1 << i);
         repeat (2) @(posedge hclk);
         check(demod_seen, 32'h1 << i);
         check(average_group_log2, (i == 5) ? 32'h2 : 32'h0);
      end
      // every rate code, short window on odd codes
      for (int r = 0; r < 4; r++) begin
         wr(32'h178, {24'h0, 2'(r), 2'(r), 1'(r), 3'h7});
         repeat (2) @(posedge hclk);
         check({correlator_rate, correlator_rate_illegal}, {2'(r), r == 3});
         check(correlation_length, (r & 1) ? 32'd32 : 32'd64);
         check(correlator_freq, 32'(r));
      end
      // reset in mid-run clears every writable register
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(correlation_length, 32'd64);
      foreach (rows[k]) begin
         i_rxscc_host.xfer(1'b0, rows[k].a, 32'h0, q);
         check(q, (rows[k].a == 32'h1FC) ? {24'h0, REV} : 32'h0);
      end
      // trim is only read, so its load value stays
      i_rxscc_host.xfer(1'b0, 32'h17C, 32'h0, q);
      check(q, 32'h0);
      check(factory_receiver_trim, 32'h0);
      check(sof_expect_valid, 32'h0);
      finish_test();
   end
endmodule
